// ===== logic/ibi_pkg.sv
/*
 * Constants, register map and carrier types for the device-side instrument bus port.
 * Assumes one 40 MHz core clock, a synchronous active-high reset and open-collector pads outside.
 */
package ibi_pkg;
    localparam int unsigned CLK_PERIOD_NS = 25;
    localparam int unsigned SETTLE_NS     = 500;
    localparam int unsigned SETTLE_CYC    = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          CNT_W         = 6;
    typedef logic [CNT_W-1:0] ibi_cnt_t;
    localparam ibi_cnt_t    SETTLE_COUNT  = ibi_cnt_t'(SETTLE_CYC);

    localparam int REG_W = 16;
    localparam int ADR_W = 4;
    localparam int IRQ_W = 5;
    localparam logic [ADR_W-1:0] OFF_CTRL     = 4'h0;
    localparam logic [ADR_W-1:0] OFF_ADDR     = 4'h1;
    localparam logic [ADR_W-1:0] OFF_STATUS   = 4'h2;
    localparam logic [ADR_W-1:0] OFF_TXDATA   = 4'h3;
    localparam logic [ADR_W-1:0] OFF_RXDATA   = 4'h4;
    localparam logic [ADR_W-1:0] OFF_IRQ_STAT = 4'h5;
    localparam logic [ADR_W-1:0] OFF_IRQ_MASK = 4'h6;
    localparam logic [ADR_W-1:0] OFF_SRQ_WORD = 4'h7;

    localparam int CTRL_ADDRABLE = 0;
    localparam int CTRL_EOI_EN   = 1;
    localparam int CTRL_SRQ_EN   = 2;
    localparam int CTRL_SRQ_REQ  = 3;
    localparam int CTRL_W        = 4;
    localparam logic [CTRL_W-1:0] CTRL_RESET  = 4'h3;
    localparam logic [4:0]        PADDR_RESET = 5'h00;

    localparam int ST_REMOTE = 0;
    localparam int ST_TALK   = 1;
    localparam int ST_LISTEN = 2;
    localparam int ST_ATN    = 3;
    localparam int ST_TXBUSY = 4;
    localparam int ST_RXVAL  = 5;
    localparam int ST_SRQ    = 6;
    localparam int ST_REN    = 7;
    localparam int TX_LAST_BIT = 8;
    localparam int RX_EOI_BIT  = 8;

    localparam int IRQ_RX     = 0;
    localparam int IRQ_TX     = 1;
    localparam int IRQ_IFC    = 2;
    localparam int IRQ_REMOTE = 3;
    localparam int IRQ_ADDR   = 4;

    localparam logic [1:0] GRP_LISTEN = 2'h1;
    localparam logic [1:0] GRP_TALK   = 2'h2;
    localparam logic [4:0] ADDR_UN    = 5'h1f;

    // raw pin levels, low means asserted
    typedef struct packed {
        logic       atn;
        logic       ren;
        logic       ifc;
        logic       eoi;
        logic       dav;
        logic       nrfd;
        logic       ndac;
        logic [7:0] dio;
    } ibi_bus_in_t;

    typedef struct packed {
        logic       eoi;
        logic       dav;
        logic       nrfd;
        logic       ndac;
        logic       srq;
        logic [7:0] dio;
    } ibi_drv_t;

    typedef enum logic [2:0] {SRC_IDLE, SRC_SETTLE, SRC_WAIT_RDY, SRC_WAIT_ACC, SRC_DONE} ibi_src_t;
    typedef enum logic [1:0] {ACC_READY, ACC_GOT, ACC_TAKEN} ibi_acc_t;
endpackage : ibi_pkg

// ===== logic/ibi_device_port.sv
/*
 * Device end of the instrument bus: pin synchronisers, source and acceptor handshakes,
 * address decode, remote/talk/listen state, service request and a small register port.
 * Assumes pads resolve out/oe_n into open-collector lines and returns raw levels on bus_in.
 */
module ibi_device_port
    import ibi_pkg::*;
(
    input  logic             core_clk,
    input  logic             rst,
    input  logic [ADR_W-1:0] reg_addr,
    input  logic [REG_W-1:0] reg_wdata,
    input  logic             reg_wr,
    input  logic             reg_rd,
    output logic [REG_W-1:0] reg_rdata,
    output logic             irq,
    input  ibi_bus_in_t      bus_in,
    output ibi_drv_t         bus_out,
    output ibi_drv_t         bus_oe_n,
    output logic             remote_led,
    output logic             talk_led,
    output logic             listen_led
);
    typedef struct packed {
        ibi_bus_in_t       s1;
        ibi_bus_in_t       s2;
        logic              ren_prev;
        logic              remote;
        logic              talk;
        logic              listen;
        logic [CTRL_W-1:0] ctrl;
        logic [4:0]        paddr;
        logic [7:0]        srq_word;
        logic [7:0]        tx_byte;
        logic              tx_last;
        logic              tx_pend;
        logic [7:0]        rx_byte;
        logic              rx_eoi;
        logic              rx_valid;
        logic [IRQ_W-1:0]  irq_stat;
        logic [IRQ_W-1:0]  irq_mask;
        ibi_src_t          src;
        ibi_acc_t          acc;
        ibi_cnt_t          cnt;
        ibi_drv_t          drv_out;
        ibi_drv_t          drv_oe_n;
        logic [REG_W-1:0]  rdata;
        logic              irq;
    } ibi_state_t;

    ibi_state_t r;
    ibi_state_t n;

    logic a_atn;
    logic a_ren;
    logic a_ifc;
    logic a_eoi;
    logic a_dav;
    logic a_nrfd;
    logic a_ndac;

    // line levels inverted once here so all logic below is active high
    assign a_atn  = ~r.s2.atn;
    assign a_ren  = ~r.s2.ren;
    assign a_ifc  = ~r.s2.ifc;
    assign a_eoi  = ~r.s2.eoi;
    assign a_dav  = ~r.s2.dav;
    assign a_nrfd = ~r.s2.nrfd;
    assign a_ndac = ~r.s2.ndac;

    function automatic logic is_mine(input logic [7:0] cmd, input logic [1:0] grp,
                                     input logic [4:0] pa, input logic en);
        is_mine = en && (cmd[6:5] == grp) && (cmd[4:0] == pa) && (pa != ADDR_UN);
    endfunction : is_mine

    assign reg_rdata  = r.rdata;
    assign irq        = r.irq;
    assign bus_out    = r.drv_out;
    assign bus_oe_n   = r.drv_oe_n;
    assign remote_led = r.remote;
    assign talk_led   = r.talk;
    assign listen_led = r.listen;

    always_comb begin
        logic [IRQ_W-1:0] ev;
        logic [IRQ_W-1:0] w1c;
        logic [REG_W-1:0] st;
        logic [7:0]       cmd;
        logic             part;
        logic             can_src;
        ev      = '0;
        w1c     = '0;
        st      = '0;
        cmd     = ~r.s2.dio;
        part    = 1'b0;
        can_src = 1'b0;
        n       = r;
        n.s1    = bus_in;
        n.s2    = r.s1;
        n.rdata = '0;

        st[ST_REMOTE] = r.remote;
        st[ST_TALK]   = r.talk;
        st[ST_LISTEN] = r.listen;
        st[ST_ATN]    = a_atn;
        st[ST_TXBUSY] = r.tx_pend;
        st[ST_RXVAL]  = r.rx_valid;
        st[ST_SRQ]    = ~r.drv_oe_n.srq;
        st[ST_REN]    = a_ren;

        if (reg_wr) begin
            if (reg_addr == OFF_CTRL) begin
                n.ctrl = reg_wdata[CTRL_W-1:0];
            end else if (reg_addr == OFF_ADDR) begin
                if (r.ctrl[CTRL_ADDRABLE]) begin
                    n.paddr = reg_wdata[4:0];
                end
            end else if (reg_addr == OFF_TXDATA) begin
                // a second byte while one is in flight is dropped; poll busy first
                if (!r.tx_pend && r.src == SRC_IDLE) begin
                    n.tx_byte = reg_wdata[7:0];
                    n.tx_last = reg_wdata[TX_LAST_BIT];
                    n.tx_pend = 1'b1;
                end
            end else if (reg_addr == OFF_IRQ_STAT) begin
                w1c = reg_wdata[IRQ_W-1:0];
            end else if (reg_addr == OFF_IRQ_MASK) begin
                n.irq_mask = reg_wdata[IRQ_W-1:0];
            end else if (reg_addr == OFF_SRQ_WORD) begin
                n.srq_word = reg_wdata[7:0];
            end
        end
        if (reg_rd) begin
            if (reg_addr == OFF_CTRL) begin
                n.rdata = {{(REG_W-CTRL_W){1'b0}}, r.ctrl};
            end else if (reg_addr == OFF_ADDR) begin
                n.rdata = {{(REG_W-5){1'b0}}, r.paddr};
            end else if (reg_addr == OFF_STATUS) begin
                n.rdata = st;
            end else if (reg_addr == OFF_TXDATA) begin
                n.rdata = {{(REG_W-9){1'b0}}, r.tx_last, r.tx_byte};
            end else if (reg_addr == OFF_RXDATA) begin
                n.rdata    = {{(REG_W-9){1'b0}}, r.rx_eoi, r.rx_byte};
                n.rx_valid = 1'b0;
            end else if (reg_addr == OFF_IRQ_STAT) begin
                n.rdata = {{(REG_W-IRQ_W){1'b0}}, r.irq_stat};
            end else if (reg_addr == OFF_IRQ_MASK) begin
                n.rdata = {{(REG_W-IRQ_W){1'b0}}, r.irq_mask};
            end else if (reg_addr == OFF_SRQ_WORD) begin
                n.rdata = {{(REG_W-8){1'b0}}, r.srq_word};
            end
        end

        n.ren_prev = a_ren;
        if (!a_ren) begin
            n.remote = 1'b0;
        end else if (!r.ren_prev) begin
            n.remote = 1'b1;
        end

        // every device takes part while ATN is true, data only when listening
        part = a_atn || r.listen;
        if (!part) begin
            n.acc = ACC_READY;
        end else begin
            case (r.acc)
                ACC_READY: begin
                    if (a_dav && (a_atn || !r.rx_valid)) begin
                        n.acc = ACC_GOT;
                        if (a_atn) begin
                            if (cmd[6:5] == GRP_LISTEN) begin
                                if (cmd[4:0] == ADDR_UN) begin
                                    n.listen = 1'b0;
                                end else if (is_mine(cmd, GRP_LISTEN, r.paddr, r.ctrl[CTRL_ADDRABLE])) begin
                                    n.listen = 1'b1;
                                    n.talk   = 1'b0;
                                    if (a_ren) begin
                                        n.remote = 1'b1;
                                    end
                                end
                            end else if (cmd[6:5] == GRP_TALK) begin
                                if (is_mine(cmd, GRP_TALK, r.paddr, r.ctrl[CTRL_ADDRABLE])) begin
                                    n.talk   = 1'b1;
                                    n.listen = 1'b0;
                                end else begin
                                    n.talk = 1'b0;
                                end
                            end
                        end else begin
                            n.rx_byte  = cmd;
                            n.rx_eoi   = a_eoi;
                            n.rx_valid = 1'b1;
                            ev[IRQ_RX] = 1'b1;
                        end
                    end
                end
                ACC_GOT: begin
                    n.acc = ACC_TAKEN;
                end
                ACC_TAKEN: begin
                    if (!a_dav) begin
                        n.acc = ACC_READY;
                    end
                end
                default: begin
                    n.acc = ACC_READY;
                end
            endcase
        end

        if (a_ifc) begin
            n.talk        = 1'b0;
            n.listen      = 1'b0;
            n.acc         = ACC_READY;
            ev[IRQ_IFC]   = 1'b1;
        end
        // remote deliberately untouched by interface clear
        n.remote = n.remote;
        ev[IRQ_REMOTE] = n.remote != r.remote;
        ev[IRQ_ADDR]   = (n.talk != r.talk) || (n.listen != r.listen);

        // ready for data only in READY with room for a data byte
        n.drv_oe_n.nrfd = !(part && !a_ifc && (n.acc != ACC_READY || (!a_atn && n.rx_valid)));
        n.drv_oe_n.ndac = !(part && !a_ifc && n.acc != ACC_TAKEN);

        can_src = n.talk && !a_atn && !a_ifc;
        if (!can_src) begin
            // aborted byte stays pending and goes out again when talking resumes
            n.src = SRC_IDLE;
        end else begin
            case (r.src)
                SRC_IDLE: begin
                    if (r.tx_pend) begin
                        n.src = SRC_SETTLE;
                        n.cnt = SETTLE_COUNT;
                    end
                end
                SRC_SETTLE: begin
                    if (r.cnt == '0) begin
                        n.src = SRC_WAIT_RDY;
                    end else begin
                        n.cnt = r.cnt - 1'b1;
                    end
                end
                SRC_WAIT_RDY: begin
                    if (!a_nrfd && a_ndac) begin
                        n.src = SRC_WAIT_ACC;
                    end
                end
                SRC_WAIT_ACC: begin
                    if (!a_ndac) begin
                        n.src      = SRC_DONE;
                        n.tx_pend  = 1'b0;
                        ev[IRQ_TX] = 1'b1;
                    end
                end
                default: begin
                    n.src = SRC_IDLE;
                end
            endcase
        end
        // data held one cycle past DAV release, never driven under ATN so no poll answer
        n.drv_oe_n.dio = (n.src != SRC_IDLE) ? ~r.tx_byte : 8'hff;
        n.drv_oe_n.eoi = !((n.src != SRC_IDLE) && r.tx_last && r.ctrl[CTRL_EOI_EN]);
        n.drv_oe_n.dav = !(n.src == SRC_WAIT_ACC);
        n.drv_oe_n.srq = !(n.ctrl[CTRL_SRQ_EN] && n.ctrl[CTRL_SRQ_REQ]);
        n.drv_out      = '0;

        n.irq_stat = (r.irq_stat & ~w1c) | ev;
        n.irq      = |(n.irq_stat & n.irq_mask);
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            r          <= '0;
            r.s1       <= '1;
            r.s2       <= '1;
            r.ctrl     <= CTRL_RESET;
            r.paddr    <= PADDR_RESET;
            r.drv_oe_n <= '1;
        end else begin
            r <= n;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    AST_IFC_IDLE: assert property (a_ifc |=> !r.talk && !r.listen && &r.drv_oe_n.dio)
        else $error("talk or listen survived interface clear");
    AST_IFC_REMOTE: assert property (a_ifc && a_ren && r.remote |=> r.remote)
        else $error("interface clear dropped remote");
    AST_REN_REMOTE: assert property ((a_ren && !r.ren_prev) |=> r.remote)
        else $error("remote not entered on enable");
    AST_DAV_OWNER: assert property (!r.drv_oe_n.dav |-> r.talk && r.drv_oe_n.ndac)
        else $error("DAV driven while not sole source");
    AST_DAV_READY: assert property ($fell(r.drv_oe_n.dav) |-> $past(r.s2.nrfd && !r.s2.ndac)
                                    && $past(r.src == SRC_WAIT_RDY) && $stable(r.drv_oe_n.dio))
        else $error("DAV asserted without ready lines or stable data");
    AST_NDAC_ORDER: assert property ($rose(r.drv_oe_n.ndac) && r.acc == ACC_TAKEN |-> !r.drv_oe_n.nrfd
                                     && $past(!r.drv_oe_n.nrfd))
        else $error("NDAC released before NRFD held");
    AST_DAV_RELEASE: assert property (r.src == SRC_WAIT_ACC && r.s2.ndac |=> r.drv_oe_n.dav ##1 r.src == SRC_IDLE)
        else $error("DAV not released after accept");
    AST_ONE_BYTE: assert property (r.acc == ACC_GOT |=> r.acc == ACC_TAKEN || r.acc == ACC_READY)
        else $error("acceptor skipped handshake step");
    AST_NO_POLL: assert property (a_atn |=> &r.drv_oe_n.dio && r.drv_oe_n.dav)
        else $error("data lines driven under ATN");
    AST_EOI_LAST: assert property (!r.drv_oe_n.eoi |-> r.tx_last && r.ctrl[CTRL_EOI_EN] && r.src != SRC_IDLE)
        else $error("EOI without last byte");
    // srq enable follows the next control value, so it lines up with the registered control
    AST_SRQ: assert property (r.ctrl[CTRL_SRQ_EN] && r.ctrl[CTRL_SRQ_REQ] |-> !r.drv_oe_n.srq)
        else $error("SRQ not asserted");
    AST_ADDR_LOCK: assert property (reg_wr && reg_addr == OFF_ADDR && !r.ctrl[CTRL_ADDRABLE] |=> $stable(r.paddr))
        else $error("address changed while not addressable");

    // talk and listen are exclusive; each own-address decode clears the other role
    AST_ROLE_EXCL: assert property (!(r.talk && r.listen))
        else $error("talk and listen set together");

    AST_QUIET_UNTALKED: assert property (!r.talk |-> r.drv_oe_n.dav && &r.drv_oe_n.dio)
        else $error("source lines driven while not talker");

    // byte must stand on the lines before DAV and for the whole handshake
    AST_DATA_FIRST: assert property (r.src != SRC_IDLE |-> r.drv_oe_n.dio == ~r.tx_byte)
        else $error("data lines differ from byte in flight");

    AST_RX_DATA_ONLY: assert property ($rose(r.rx_valid) |-> $past(!a_atn))
        else $error("data byte taken while attention true");

    // unread byte keeps not-ready low; a read in the same cycle frees it
    AST_RX_HOLD: assert property (r.listen && !a_atn && !a_ifc && r.rx_valid && r.acc == ACC_READY
                                  && !(reg_rd && reg_addr == OFF_RXDATA) |=> !r.drv_oe_n.nrfd)
        else $error("not-ready released with unread byte");

    AST_UNLISTEN: assert property (a_atn && !a_ifc && a_dav && r.acc == ACC_READY
                                   && (~r.s2.dio[6:0]) == {GRP_LISTEN, ADDR_UN} |=> !r.listen)
        else $error("listener kept after unlisten");

    COV_TX: cover property (r.src == SRC_WAIT_ACC ##[1:100] r.src == SRC_DONE);
    COV_RX: cover property ($rose(r.rx_valid));
    COV_LISTEN: cover property ($rose(r.listen));
    COV_IFC: cover property (a_ifc && r.remote);
    COV_UNLISTEN: cover property ($fell(r.listen) && !$past(a_ifc));
endmodule : ibi_device_port

// ===== bench/ibi_ctrl_model.sv
/*
 * Behavioural bus controller for the instrument bus port: drives ATN, REN, IFC and EOI,
 * sources bytes and accepts bytes over the three-wire handshake.
 * Assumes the bench resolves every open-collector line and feeds the levels back on bus.
 */
module ibi_ctrl_model
    import ibi_pkg::*;
(
    input  logic        core_clk,
    input  ibi_bus_in_t bus,
    output ibi_bus_in_t drv,
    output int          stall_cnt
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        drv = '1;
        stall_cnt = 0;
    end

    function automatic logic line(input int sel);
        return (sel == 0) ? bus.dav : ((sel == 1) ? bus.nrfd : bus.ndac);
    endfunction : line

    // bounded so a dead handshake shows up as a stall, not a hang
    task automatic wait_line(input int sel, input logic lvl);
        int n;
        n = 0;
        while (line(sel) !== lvl && n < 4000) begin
            @(posedge core_clk);
            n++;
        end
        if (n == 4000) stall_cnt++;
    endtask : wait_line

    task automatic set_mgmt(input logic atn_t, input logic ren_t, input logic ifc_t, input logic eoi_t);
        @(posedge core_clk);
        drv.atn <= ~atn_t;
        drv.ren <= ~ren_t;
        drv.ifc <= ~ifc_t;
        drv.eoi <= ~eoi_t;
    endtask : set_mgmt

    // an edge first, so a previous call's release of dio and eoi is not overwritten in the same step
    task automatic send(input logic [7:0] b, input logic last);
        @(posedge core_clk);
        drv.dio <= ~b;
        drv.eoi <= ~last;
        @(posedge core_clk);
        wait_line(2, 1'b0);
        wait_line(1, 1'b1);
        drv.dav <= 1'b0;
        wait_line(2, 1'b1);
        drv.dav <= 1'b1;
        wait_line(2, 1'b0);
        drv.dio <= 8'hff;
        drv.eoi <= 1'b1;
    endtask : send

    // dly holds NDAC low longer, acting as a slow listener
    task automatic accept(input int dly, output logic [8:0] got);
        drv.ndac <= 1'b0;
        drv.nrfd <= 1'b1;
        @(posedge core_clk);
        wait_line(0, 1'b0);
        drv.nrfd <= 1'b0;
        got = {~bus.eoi, ~bus.dio};
        repeat (dly + 1) @(posedge core_clk);
        drv.ndac <= 1'b1;
        wait_line(0, 1'b1);
        drv.ndac <= 1'b0;
        @(posedge core_clk);
        drv.nrfd <= 1'b1;
        drv.ndac <= 1'b1;
    endtask : accept
endmodule : ibi_ctrl_model

// ===== bench/tb_top.sv
/*
 * Self-checking bench for the device-side instrument bus port, register calls plus bus sequences.
 * Assumes ibi_ctrl_model stands on the far side and lines are wired-AND with pull-ups.
 */
module tb_top
    import ibi_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic             core_clk;
    logic             rst;
    logic [ADR_W-1:0] reg_addr;
    logic [REG_W-1:0] reg_wdata;
    logic             reg_wr;
    logic             reg_rd;
    logic [REG_W-1:0] reg_rdata;
    logic             irq;
    ibi_bus_in_t      bus_in;
    ibi_bus_in_t      ctl_drv;
    ibi_drv_t         bus_out;
    ibi_drv_t         bus_oe_n;
    logic             remote_led;
    logic             talk_led;
    logic             listen_led;
    logic             srq_line;
    logic [REG_W-1:0] rd;
    logic [8:0]       got;
    int               stall_cnt;
    int               failures    = 0;
    int               comparisons = 0;
    int               cyc         = 0;
    logic [15:0]      ctrl_tab [3] = '{16'h0003, 16'h0003, 16'h0001};
    logic [15:0]      tx_tab   [3] = '{16'h005a, 16'h013c, 16'h013c};
    logic [15:0]      exp_tab  [3] = '{16'h005a, 16'h013c, 16'h003c};
    int               dly_tab  [3] = '{0, 6, 0};

    function automatic logic res(input logic m, input logic oe_n, input logic o);
        return m & (oe_n ? 1'b1 : o);
    endfunction : res

    always_comb begin
        bus_in = ctl_drv;
        bus_in.eoi = res(ctl_drv.eoi, bus_oe_n.eoi, bus_out.eoi);
        bus_in.dav = res(ctl_drv.dav, bus_oe_n.dav, bus_out.dav);
        bus_in.nrfd = res(ctl_drv.nrfd, bus_oe_n.nrfd, bus_out.nrfd);
        bus_in.ndac = res(ctl_drv.ndac, bus_oe_n.ndac, bus_out.ndac);
        for (int i = 0; i < 8; i++) begin
            bus_in.dio[i] = res(ctl_drv.dio[i], bus_oe_n.dio[i], bus_out.dio[i]);
        end
        srq_line = bus_oe_n.srq ? 1'b1 : bus_out.srq;
    end

    ibi_device_port uut (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq), .bus_in(bus_in),
        .bus_out(bus_out), .bus_oe_n(bus_oe_n), .remote_led(remote_led), .talk_led(talk_led),
        .listen_led(listen_led));
    ibi_ctrl_model ctl (.core_clk(core_clk), .bus(bus_in), .drv(ctl_drv), .stall_cnt(stall_cnt));

    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : wait_cyc

    task automatic check(input logic [15:0] g, input logic [15:0] e);
        comparisons++;
        if (g !== e) begin
            failures++;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
        end
    endtask : check

    task automatic reg_write(input logic [ADR_W-1:0] a, input logic [REG_W-1:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask : reg_write

    task automatic expect_reg(input logic [ADR_W-1:0] a, input logic [REG_W-1:0] e);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        rd = reg_rdata;
        check(rd, e);
    endtask : expect_reg

    task automatic wrap_up;
        failures += stall_cnt;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : wrap_up

    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 20000) begin
            failures++;
            wrap_up();
        end
    end

    // only a talker may ever pull the valid line
    always @(posedge core_clk) begin
        if (!rst && bus_oe_n.dav === 1'b0 && talk_led !== 1'b1) begin
            failures++;
            $display("unexpected at %0t: got %h expected %h", $time, talk_led, 1'b1);
        end
    end

    initial begin
        rst = 1'b1;
        reg_addr = '0;
        reg_wdata = '0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        expect_reg(OFF_CTRL, 16'h0003);
        expect_reg(OFF_ADDR, 16'h0000);
        expect_reg(OFF_STATUS, 16'h0000);
        expect_reg(4'h9, 16'h0000);
        check({13'h0, remote_led, talk_led, listen_led}, 16'h0000);
        reg_write(OFF_ADDR, 16'h0005);
        ctl.set_mgmt(1'b0, 1'b1, 1'b0, 1'b0);
        wait_cyc(5);
        check({15'h0, remote_led}, 16'h0001);
        ctl.set_mgmt(1'b1, 1'b1, 1'b0, 1'b0);
        ctl.send(8'ha7, 1'b0);
        wait_cyc(4);
        check({15'h0, listen_led}, 16'h0000);
        ctl.send(8'h25, 1'b0);
        wait_cyc(4);
        check({15'h0, listen_led}, 16'h0001);
        expect_reg(OFF_STATUS, 16'h008d);
        ctl.set_mgmt(1'b0, 1'b1, 1'b0, 1'b0);
        ctl.send(8'ha5, 1'b1);
        wait_cyc(3);
        check({15'h0, irq}, 16'h0000);
        reg_write(OFF_IRQ_MASK, 16'h0001);
        wait_cyc(3);
        check({15'h0, irq}, 16'h0001);
        expect_reg(OFF_RXDATA, 16'h01a5);
        reg_write(OFF_IRQ_STAT, 16'h001f);
        wait_cyc(3);
        check({15'h0, irq}, 16'h0000);
        expect_reg(OFF_IRQ_STAT, 16'h0000);
        reg_write(OFF_CTRL, 16'h0000);
        reg_write(OFF_ADDR, 16'h0009);
        expect_reg(OFF_ADDR, 16'h0005);
        reg_write(OFF_CTRL, 16'h0003);
        ctl.set_mgmt(1'b1, 1'b1, 1'b0, 1'b0);
        ctl.send(8'h3f, 1'b0);
        wait_cyc(4);
        check({15'h0, listen_led}, 16'h0000);
        ctl.send(8'h45, 1'b0);
        wait_cyc(4);
        check({14'h0, talk_led, listen_led}, 16'h0002);
        ctl.set_mgmt(1'b0, 1'b1, 1'b0, 1'b0);
        for (int i = 0; i < 3; i++) begin
            reg_write(OFF_CTRL, ctrl_tab[i]);
            reg_write(OFF_TXDATA, tx_tab[i]);
            ctl.accept(dly_tab[i], got);
            check({7'h0, got}, exp_tab[i]);
        end
        reg_write(OFF_SRQ_WORD, 16'h0042);
        reg_write(OFF_CTRL, 16'h000f);
        wait_cyc(3);
        check({15'h0, srq_line}, 16'h0000);
        expect_reg(OFF_SRQ_WORD, 16'h0042);
        reg_write(OFF_CTRL, 16'h000b);
        wait_cyc(3);
        check({15'h0, srq_line}, 16'h0001);
        ctl.set_mgmt(1'b1, 1'b1, 1'b0, 1'b1);
        wait_cyc(10);
        check({8'h0, bus_oe_n.dio}, 16'h00ff);
        ctl.set_mgmt(1'b0, 1'b1, 1'b1, 1'b0);
        wait_cyc(6);
        check({13'h0, remote_led, talk_led, listen_led}, 16'h0004);
        ctl.set_mgmt(1'b0, 1'b1, 1'b0, 1'b0);
        reg_write(OFF_TXDATA, 16'h0011);
        wait_cyc(40);
        check({7'h0, bus_oe_n.dav, bus_oe_n.dio}, 16'h01ff);
        ctl.set_mgmt(1'b0, 1'b0, 1'b0, 1'b0);
        wait_cyc(5);
        check({15'h0, remote_led}, 16'h0000);
        wrap_up();
    end
endmodule : tb_top
